// ---- inc/apl_pkg.sv ----
package apl_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;

	// register byte offsets, one aligned word each
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SETUP = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_CLEAR = 8'h10;
	localparam logic [7:0] OFS_ANGLE = 8'h14;
	localparam logic [7:0] OFS_COEF = 8'h80;

	// control word fields
	localparam int CTRL_ERR_EN = 0;
	localparam int CTRL_ERR_STYLE = 1;
	localparam int CTRL_CORR_EN = 2;
	localparam int CTRL_SCALE = 3;
	localparam int CTRL_W = 4;
	localparam int SETUP_STEP_LSB = 0;
	localparam int SETUP_STEP_W = 4;
	localparam int SETUP_BAND_LSB = 4;
	localparam int SETUP_BAND_W = 3;
	localparam int SETUP_W = 7;
	localparam int CLEAR_OVF_BIT = 0;
	localparam int STAT_TRI_BIT = 13;
	localparam int STAT_ERRMODE_BIT = 14;
	localparam int STAT_SEL_LSB = 16;
	localparam int ANGLE_HOLD_LSB = 16;

	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
	localparam logic [SETUP_W-1:0] SETUP_RST = 7'h00;

	// error sources, index equals priority minus one
	localparam int NUM_ERR = 13;
	localparam int ERR_WDOG = 0;
	localparam int ERR_AVG = 5;
	localparam int ERR_ECC = 8;
	localparam int ERR_OVF = 12;
	localparam logic [NUM_ERR-1:0] MASK_RST = 13'h0000;
	localparam logic [NUM_ERR-1:0] PERM_ERRS = 13'h0007;
	localparam logic [NUM_ERR-1:0] ONCE_ERRS = 13'h0120;

	// angle correction
	localparam int ANGLE_W = 12;
	localparam int COEF_W = 12;
	localparam int NUM_COEF = 32;
	localparam int SEG_FRAC_W = 7;
	localparam logic [COEF_W-1:0] COEF_RST = 12'h000;

	// duty cycle, all as fractions of DUTY_DEN
	localparam int unsigned PWM_FLOOR_PCT = 5;
	localparam int unsigned PWM_SPAN_PCT = 90;
	localparam int unsigned PCT_FULL = 100;
	localparam int unsigned ERR_DUTY_BASE_X8 = 40;
	localparam int unsigned ERR_DUTY_STEP_X8 = 45;
	localparam int unsigned DUTY_DEN = PCT_FULL * (1 << ANGLE_W);
	localparam int unsigned ERR_DUTY_SCALE = DUTY_DEN / (PCT_FULL * 8);

	// carrier period in clocks: base + ((band step + step * freq) << band)
	localparam int unsigned PER_BASE_CYC = 14000;
	localparam int unsigned PER_BAND_CYC = 2000;
	localparam int unsigned PER_STEP_CYC = 125;
	localparam int PER_W = 20;

	typedef enum logic [1:0] {APL_ANGLE, APL_TRISTATE, APL_ERROR} apl_mode_t;
endpackage

// ---- src/apl_pwm_linearizer.sv ----
// How it works
// - error reporting on only when enable set
// - style zero: release output during errors
// - style one: double period, error duty
// - lowest index active error wins
// - masked errors never touch the output
// - watchdog: priority 1, 5 percent, permanent
// - uncorrectable memory: priority 2, permanent
// - self-test failure: priority 3, permanent
// - pll unlocked: priority 4, until lock
// - zero-cross error: priority 5, while present
// - averaging error: priority 6, shown once
// - undervoltage: priority 7, while present
// - weak field 8, strong field 11
// - corrected memory: priority 9, shown once
// - clipping warning: priority 10, while present
// - temperature: priority 12, while out of range
// - overflow: priority 13, host clears it
// - 32 coefficients every 11.25 degrees subtracted
// - coefficients signed 12 bit, positive lowers
// - scale bit picks 22.5 or 45 degrees
// - interpolate linearly between neighbouring points
// - same latency with correction on or off
// - angle maps 5 to 95 percent duty
// - first 5 percent high, last low
// - period from 16 steps times 8 bands
// - angle latched at period start only
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module apl_pwm_linearizer import apl_pkg::*; #(
	parameter int unsigned PER_BASE = PER_BASE_CYC,
	parameter int unsigned PER_BAND = PER_BAND_CYC,
	parameter int unsigned PER_STEP = PER_STEP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [ANGLE_W-1:0] angle_in,
	input wire logic watchdog_error,
	input wire logic eeprom_uncorrectable_error,
	input wire logic self_test_failure,
	input wire logic pll_unlocked,
	input wire logic zero_cross_integrity_error,
	input wire logic angle_averaging_error,
	input wire logic undervoltage_error,
	input wire logic weak_field_error,
	input wire logic ecc_corrected_fault,
	input wire logic field_clipping_warning,
	input wire logic strong_field_error,
	input wire logic temperature_range_error,
	input wire logic overflow_error,
	output logic pwm_o,
	output logic pwm_oe
);
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		be_merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				be_merge[8*i+:8] = wd[8*i+:8];
			end
		end
	endfunction

	function automatic logic [3:0] first_idx(input logic [NUM_ERR-1:0] v);
		first_idx = 4'h0;
		for (int i = NUM_ERR - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_idx = 4'(i);
			end
		end
	endfunction

	// bus slave: one wait cycle, then the answer
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic acc;
	logic wr_take;
	logic is_coef;
	logic [4:0] coef_idx;
	logic [CTRL_W-1:0] ctrl_q;
	logic [SETUP_W-1:0] setup_q;
	logic [NUM_ERR-1:0] mask_q;
	logic [COEF_W-1:0] coef_q [NUM_COEF];
	logic ovf_clear;

	assign acc = avs_read | avs_write;
	assign avs_waitrequest = acc & ~ack_q;
	assign avs_readdata = rdata_q;
	assign wr_take = avs_write & ack_q;
	assign is_coef = avs_address[7];
	assign coef_idx = avs_address[6:2];
	assign ovf_clear = wr_take && avs_address == OFS_CLEAR && avs_byteenable[0]
		&& avs_writedata[CLEAR_OVF_BIT];

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc & ~ack_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			setup_q <= SETUP_RST;
			mask_q <= MASK_RST;
		end else if (wr_take && !is_coef) begin
			unique case (avs_address)
				OFS_CTRL: ctrl_q <= CTRL_W'(be_merge(32'(ctrl_q), avs_writedata, avs_byteenable));
				OFS_SETUP: setup_q <= SETUP_W'(be_merge(32'(setup_q), avs_writedata,
					avs_byteenable));
				OFS_MASK: mask_q <= NUM_ERR'(be_merge(32'(mask_q), avs_writedata, avs_byteenable));
				default: begin
				end
			endcase
		end
	end

	// coefficients double as free user storage when correction is off
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_COEF; i++) begin
				coef_q[i] <= COEF_RST;
			end
		end else if (wr_take && is_coef) begin
			coef_q[coef_idx] <= COEF_W'(be_merge(32'(coef_q[coef_idx]), avs_writedata,
				avs_byteenable));
		end
	end

	// error sources
	logic [NUM_ERR-1:0] sticky_q;
	logic [NUM_ERR-1:0] pls;
	logic [NUM_ERR-1:0] lvl;
	logic [NUM_ERR-1:0] act;
	logic [NUM_ERR-1:0] unm;
	logic [NUM_ERR-1:0] clr_once;
	logic [NUM_ERR-1:0] clr;
	logic [NUM_ERR-1:0] keep;

	assign pls = {overflow_error, 3'b000, ecc_corrected_fault, 2'b00, angle_averaging_error,
		2'b00, self_test_failure, eeprom_uncorrectable_error, watchdog_error};
	assign lvl = {1'b0, temperature_range_error, strong_field_error, field_clipping_warning,
		1'b0, weak_field_error, undervoltage_error, 1'b0, zero_cross_integrity_error,
		pll_unlocked, 3'b000};
	assign act = sticky_q | lvl;
	// a one-shot flag dropped at this start must not choose the new period
	assign keep = sticky_q & ~(clr & ~PERM_ERRS);
	assign unm = (keep | lvl) & ~mask_q;
	assign clr = clr_once | (ovf_clear ? (NUM_ERR'(1) << ERR_OVF) : '0);

	// set wins over clear; permanent bits are never in clr
	always_ff @(posedge clk) begin
		if (rst) begin
			sticky_q <= '0;
		end else begin
			sticky_q <= keep | pls;
		end
	end

	// correction: segment of 128 codes, coefficient pair wraps at 360
	logic [4:0] seg;
	logic [SEG_FRAC_W-1:0] frac;
	logic signed [COEF_W-1:0] c0;
	logic signed [COEF_W-1:0] c1;
	logic signed [COEF_W:0] dlt;
	logic signed [20:0] prod;
	logic signed [20:0] corr;
	logic signed [21:0] scaled;
	logic signed [23:0] sum;
	logic [ANGLE_W-1:0] corr_angle_q;

	assign seg = angle_in[ANGLE_W-1:SEG_FRAC_W];
	assign frac = angle_in[SEG_FRAC_W-1:0];
	assign c0 = coef_q[seg];
	assign c1 = coef_q[5'(seg + 5'h01)];
	assign dlt = {c1[COEF_W-1], c1} - {c0[COEF_W-1], c0};
	assign prod = 21'(dlt * $signed({1'b0, frac}));
	assign corr = {{2{c0[COEF_W-1]}}, c0, 7'h00} + prod;
	always_comb begin
		scaled = '0;
		if (ctrl_q[CTRL_CORR_EN]) begin
			scaled = ctrl_q[CTRL_SCALE] ? {corr, 1'b0} : {corr[20], corr};
		end
	end
	// ten fraction bits, rounded to nearest code; wrap is modulo 360
	assign sum = $signed({2'b00, angle_in, 10'h000}) - {{2{scaled[21]}}, scaled}
		+ 24'sh000200;

	// registered in both modes so the delay never changes
	always_ff @(posedge clk) begin
		if (rst) begin
			corr_angle_q <= '0;
		end else begin
			corr_angle_q <= sum[21:10];
		end
	end

	// carrier period engine
	logic [PER_W-1:0] cnt_q;
	logic [PER_W-1:0] per_q;
	logic [PER_W-1:0] per_d;
	logic [PER_W-1:0] base_per;
	logic [39:0] thr_q;
	logic [39:0] thr_d;
	logic [18:0] num_d;
	apl_mode_t mode_q;
	apl_mode_t mode_d;
	logic [3:0] sel_q;
	logic [3:0] sel_d;
	logic [NUM_ERR-1:0] once_seen_q;
	logic [ANGLE_W-1:0] ang_hold_q;
	logic start;
	logic high;

	assign start = cnt_q == per_q - 20'h00001;
	assign base_per = PER_W'(PER_BASE + ((PER_BAND + PER_STEP
		* setup_q[SETUP_STEP_LSB+:SETUP_STEP_W]) << setup_q[SETUP_BAND_LSB+:SETUP_BAND_W]));
	assign sel_d = first_idx(unm);

	always_comb begin
		mode_d = APL_ANGLE;
		if (ctrl_q[CTRL_ERR_EN] && unm != '0) begin
			mode_d = ctrl_q[CTRL_ERR_STYLE] ? APL_ERROR : APL_TRISTATE;
		end
	end

	always_comb begin
		per_d = base_per;
		num_d = '0;
		unique case (mode_d)
			APL_ANGLE: begin
				num_d = 19'(PWM_FLOOR_PCT * (1 << ANGLE_W) + PWM_SPAN_PCT * corr_angle_q);
			end
			APL_TRISTATE: begin
				num_d = '0;
			end
			APL_ERROR: begin
				per_d = {base_per[PER_W-2:0], 1'b0};
				num_d = 19'((ERR_DUTY_BASE_X8 + ERR_DUTY_STEP_X8 * sel_d) * ERR_DUTY_SCALE);
			end
		endcase
	end
	assign thr_d = 40'(per_d) * 40'(num_d);

	// everything that shapes a period is taken at its first edge
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
			per_q <= 20'h00001;
			thr_q <= '0;
			mode_q <= APL_ANGLE;
			sel_q <= 4'h0;
			ang_hold_q <= '0;
			once_seen_q <= '0;
		end else if (start) begin
			cnt_q <= '0;
			per_q <= per_d;
			thr_q <= thr_d;
			mode_q <= mode_d;
			sel_q <= sel_d;
			ang_hold_q <= corr_angle_q;
			// only flags that outlive this start are remembered
			once_seen_q <= keep & ONCE_ERRS;
		end else begin
			cnt_q <= cnt_q + 20'h00001;
		end
	end

	// a one-shot error is dropped after a period that showed it or could not show it
	always_comb begin
		clr_once = '0;
		for (int i = 0; i < NUM_ERR; i++) begin
			if (start && once_seen_q[i] && (mode_q != APL_ERROR || sel_q == 4'(i) || mask_q[i])) begin
				clr_once[i] = 1'b1;
			end
		end
	end

	// open drain: enable pulls the line low; released means high
	assign high = 40'(cnt_q) * 40'(DUTY_DEN) < thr_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			pwm_oe <= 1'b0;
			pwm_o <= 1'b0;
		end else begin
			pwm_oe <= mode_q != APL_TRISTATE && !high;
			pwm_o <= 1'b0;
		end
	end

	always_comb begin
		rdata_d = '0;
		if (is_coef) begin
			rdata_d = 32'($signed(coef_q[coef_idx]));
		end else begin
			unique case (avs_address)
				OFS_CTRL: rdata_d = 32'(ctrl_q);
				OFS_SETUP: rdata_d = 32'(setup_q);
				OFS_MASK: rdata_d = 32'(mask_q);
				OFS_STATUS: begin
					rdata_d[NUM_ERR-1:0] = act;
					rdata_d[STAT_TRI_BIT] = mode_q == APL_TRISTATE;
					rdata_d[STAT_ERRMODE_BIT] = mode_q == APL_ERROR;
					rdata_d[STAT_SEL_LSB+:4] = sel_q;
				end
				OFS_ANGLE: begin
					rdata_d[ANGLE_W-1:0] = corr_angle_q;
					rdata_d[ANGLE_HOLD_LSB+:ANGLE_W] = ang_hold_q;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (acc && !ack_q) begin
			rdata_q <= rdata_d;
		end
	end

	ignore_err_a: assert property (@(posedge clk) disable iff (rst)
		start && !ctrl_q[CTRL_ERR_EN] |=> mode_q == APL_ANGLE)
		else $error("error shown while reporting is off");
	tristate_a: assert property (@(posedge clk) disable iff (rst)
		start && ctrl_q[CTRL_ERR_EN] && !ctrl_q[CTRL_ERR_STYLE] && unm != '0
		|=> mode_q == APL_TRISTATE ##1 !pwm_oe [*2])
		else $error("output not released on error");
	half_freq_a: assert property (@(posedge clk) disable iff (rst)
		start && ctrl_q[CTRL_ERR_EN] && ctrl_q[CTRL_ERR_STYLE] && unm != '0
		|=> mode_q == APL_ERROR && per_q == {$past(base_per[PER_W-2:0]), 1'b0})
		else $error("error period not doubled");
	prio_pick_a: assert property (@(posedge clk) disable iff (rst)
		!rst && start && unm != '0
		|=> (($past(unm) >> sel_q) & NUM_ERR'(1)) == NUM_ERR'(1)
		&& ($past(unm) & ((NUM_ERR'(1) << sel_q) - NUM_ERR'(1))) == '0)
		else $error("wrong error priority chosen");
	mask_gate_a: assert property (@(posedge clk) disable iff (rst)
		start && (act & ~mask_q) == '0 |=> mode_q == APL_ANGLE)
		else $error("masked error changed output");
	perm_keep_a: assert property (@(posedge clk) disable iff (rst)
		sticky_q != '0 |=> (($past(sticky_q) & ~sticky_q) & PERM_ERRS) == '0)
		else $error("permanent error cleared");
	ovf_hold_a: assert property (@(posedge clk) disable iff (rst)
		sticky_q[ERR_OVF] && !ovf_clear |=> sticky_q[ERR_OVF])
		else $error("overflow lost without host clear");
	fixed_delay_a: assert property (@(posedge clk) disable iff (rst)
		!rst && !ctrl_q[CTRL_CORR_EN] |=> corr_angle_q == $past(angle_in))
		else $error("uncorrected angle delay wrong");
	latch_hold_a: assert property (@(posedge clk) disable iff (rst)
		!start |=> $stable(ang_hold_q) && $stable(thr_q) && $stable(mode_q))
		else $error("period setting changed mid period");
	frame_edge_a: assert property (@(posedge clk) disable iff (rst)
		mode_q != APL_TRISTATE && per_q > 20'h00002 && cnt_q == per_q - 20'h00002
		|=> pwm_oe [*2] ##1 !pwm_oe)
		else $error("period end or start level wrong");
endmodule
`default_nettype wire

// ---- test/apl_pwm_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// host side decoder: measures period and high time between rising edges of the line
module apl_pwm_host (
	input wire logic clk,
	input wire logic pwm_o,
	input wire logic pwm_oe,
	output logic [15:0] high_cnt,
	output logic [15:0] per_cnt,
	output logic [15:0] meas_n
);
	logic line;
	logic line_prev;
	logic [15:0] run_per;
	logic [15:0] run_high;
	// open drain with pull-up: released line reads high
	assign line = pwm_oe ? pwm_o : 1'b1;
	initial begin
		line_prev = 1'b1;
		run_per = 16'h0000;
		run_high = 16'h0000;
		high_cnt = 16'h0000;
		per_cnt = 16'h0000;
		meas_n = 16'h0000;
	end
	always @(posedge clk) begin
		line_prev <= line;
		if (line && !line_prev) begin
			per_cnt <= run_per;
			high_cnt <= run_high;
			run_per <= 16'h0001;
			run_high <= 16'h0001;
			meas_n <= meas_n + 16'h0001;
		end else begin
			run_per <= run_per + 16'h0001;
			run_high <= run_high + {15'h0000, line};
		end
	end
endmodule
`default_nettype wire

// ---- test/apl_pwm_linearizer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module apl_pwm_linearizer_tb_top import apl_pkg::*;;
	localparam int unsigned PB = 40;
	localparam int unsigned PBA = 20;
	localparam int unsigned PS = 2;
	localparam int unsigned PER0 = PB + PBA;
	localparam logic [NUM_ERR-1:0] PULSED = PERM_ERRS | ONCE_ERRS | 13'h1000;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, pwm_o, pwm_oe;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic [ANGLE_W-1:0] angle_in;
	logic [NUM_ERR-1:0] err;
	logic [15:0] high_cnt, per_cnt, meas_n;
	int mismatches, cmp_count;
	int unsigned tb_ang [5] = '{0, 64, 4032, 0, 64};
	logic [31:0] tb_ctl [5] = '{32'h4, 32'h4, 32'h4, 32'hc, 32'h0};
	int unsigned tb_exp [5] = '{4086, 58, 4037, 4076, 64};
	apl_pwm_linearizer #(.PER_BASE(PB), .PER_BAND(PBA), .PER_STEP(PS)) i_apl_pwm_linearizer (
		.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .angle_in(angle_in),
		.watchdog_error(err[0]), .eeprom_uncorrectable_error(err[1]),
		.self_test_failure(err[2]), .pll_unlocked(err[3]),
		.zero_cross_integrity_error(err[4]), .angle_averaging_error(err[5]),
		.undervoltage_error(err[6]), .weak_field_error(err[7]),
		.ecc_corrected_fault(err[8]), .field_clipping_warning(err[9]),
		.strong_field_error(err[10]), .temperature_range_error(err[11]),
		.overflow_error(err[12]), .pwm_o(pwm_o), .pwm_oe(pwm_oe));
	apl_pwm_host i_apl_pwm_host (.clk(clk), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
		.high_cnt(high_cnt), .per_cnt(per_cnt), .meas_n(meas_n));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic complete_run();
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		bus(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask
	task automatic wait_meas(input int n);
		logic [15:0] s;
		repeat (n) begin
			s = meas_n;
			for (int k = 0; k < 2000 && meas_n == s; k++) @(posedge clk);
			if (meas_n == s)
				mismatches++;
		end
	endtask
	task automatic pwm_chk(input int unsigned per, input int unsigned num, input string name);
		check({name, " period"}, {16'h0, per_cnt}, per);
		check({name, " high"}, {16'h0, high_cnt}, (per * num + DUTY_DEN - 1) / DUTY_DEN);
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
	endtask
	function automatic int unsigned err_num(input int i);
		return (ERR_DUTY_BASE_X8 + ERR_DUTY_STEP_X8 * i) * ERR_DUTY_SCALE;
	endfunction
	initial begin
		repeat (50000) @(posedge clk);
		mismatches++;
		complete_run();
	end
	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		angle_in = 12'h000;
		err = 13'h0000;
		mismatches = 0;
		cmp_count = 0;
		do_reset();
		rd_chk(OFS_CTRL, 32'h0, "ctrl reset");
		rd_chk(OFS_SETUP, 32'h0, "setup reset");
		rd_chk(OFS_MASK, 32'h0, "mask reset");
		bus(1'b1, 8'h40, 32'hffffffff);
		rd_chk(8'h40, 32'h0, "unmapped");
		bus(1'b1, OFS_COEF + 8'h04, 32'h00000f00);
		rd_chk(OFS_COEF + 8'h04, 32'hffffff00, "coef sign");
		foreach (tb_exp[j]) begin
			angle_in <= 12'(j * 2047);
			wait_meas(3);
			pwm_chk(PER0, 20480 + PWM_SPAN_PCT * ((j * 2047) % (1 << ANGLE_W)), "angle duty");
		end
		bus(1'b1, OFS_SETUP, 32'h23);
		wait_meas(3);
		pwm_chk(PB + ((PBA + 3 * PS) << 2), 20480 + PWM_SPAN_PCT * 4092, "carrier");
		bus(1'b1, OFS_SETUP, 32'h0);
		bus(1'b1, OFS_COEF, 32'd80);
		bus(1'b1, OFS_COEF + 8'h04, 32'd16);
		bus(1'b1, OFS_COEF + 8'h7c, 32'hffffff60);
		foreach (tb_exp[j]) begin
			angle_in <= tb_ang[j][11:0];
			bus(1'b1, OFS_CTRL, tb_ctl[j]);
			bus(1'b0, OFS_ANGLE, 32'h0);
			check("settle", rd & 32'hfff, tb_exp[j]);
			bus(1'b0, OFS_ANGLE, 32'h0);
			check("corrected", rd & 32'hfff, tb_exp[j]);
			cmp_count++;
		end
		for (int i = 0; i < NUM_ERR; i++) begin
			do_reset();
			bus(1'b1, OFS_CTRL, 32'h3);
			err[i] <= 1'b1;
			@(posedge clk);
			if (PULSED[i])
				err[i] <= 1'b0;
			wait_meas(2);
			pwm_chk(2 * PER0, err_num(i), "error duty");
			err[i] <= 1'b0;
			wait_meas(3);
			check("error hold", {16'h0, per_cnt}, (PERM_ERRS[i] || i == ERR_OVF) ? 2 * PER0 : PER0);
			if (i == ERR_OVF) begin
				bus(1'b1, OFS_CLEAR, 32'h1);
				wait_meas(3);
				check("overflow clear", {16'h0, per_cnt}, PER0);
			end
		end
		do_reset();
		bus(1'b1, OFS_CTRL, 32'h3);
		err <= 13'h0208;
		wait_meas(3);
		pwm_chk(2 * PER0, err_num(3), "priority");
		bus(1'b0, OFS_STATUS, 32'h0);
		check("status mode", {25'h0, rd[19:13]}, 32'h1a);
		bus(1'b0, OFS_STATUS, 32'h0);
		check("status raw", rd & 32'h1fff, 32'h208);
		bus(1'b1, OFS_MASK, 32'h8);
		wait_meas(3);
		pwm_chk(2 * PER0, err_num(9), "masked one");
		bus(1'b1, OFS_MASK, 32'h208);
		wait_meas(3);
		pwm_chk(PER0, 20480 + PWM_SPAN_PCT * 64, "masked all");
		bus(1'b1, OFS_MASK, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h0);
		wait_meas(3);
		pwm_chk(PER0, 20480 + PWM_SPAN_PCT * 64, "report off");
		bus(1'b1, OFS_CTRL, 32'h1);
		wait_meas(1);
		// the line never rises again while released, so watch the enable directly
		for (int k = 0; k < 3 * PER0; k++) begin
			@(posedge clk);
			if (pwm_oe !== 1'b0)
				k = 3 * PER0 + 1;
		end
		check("tristate", {31'h0, pwm_oe}, 32'h0);
		err <= 13'h0000;
		wait_meas(3);
		pwm_chk(PER0, 20480 + PWM_SPAN_PCT * 64, "recover");
		complete_run();
	end
endmodule
`default_nettype wire
